// file: fsfl_flags.sv
// Status flag logic of a deep FIFO seen as two dies: full/input-ready, empty/output-ready,
// almost-full and almost-empty, in standard and fall-through modes, with a register bus.
// Assumes write and read ports share I_CLOCK and all inputs are synchronous to it.
// Contract
// - Standard: full flag low when full, blocks writes
// - Full after depth writes without reads
// - Fall-through: input-ready low while space exists
// - Input-ready counts output register word too
// - Full/input-ready through two register stages
// - Retransmit: write pointer compared with mark
// - Standard: empty flag low when no words
// - Output-ready falls when first word reaches outputs
// - Output-ready rises only on true read
// - Empty two stages, output-ready three stages
// - Standard almost-full after depth minus m writes
// - Fall-through almost-full one write later
// - Almost-full timing: asynchronous or synchronous
// - Standard almost-empty at count at most n
// - Fall-through almost-empty at most n plus one
// - Almost-empty timing: asynchronous or synchronous
// - Master reset straps select offset preset
// - Timing select strap caught at master reset
// - Reads ignored while memory empty
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsfl_consts.svh"

module fsfl_flags #(
  parameter int DEPTH = `FSFL_DEPTH,
  parameter int PTR_W = $clog2(DEPTH) + 1
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire fsfl_pkg::fsfl_axi_req_type I_AXI_REQ,
  output fsfl_pkg::fsfl_axi_rsp_type O_AXI_RSP,
  input wire logic I_MASTER_RESET_N,
  input wire logic I_PARTIAL_RESET_N,
  input wire logic I_FALL_THROUGH_MODE,
  input wire logic I_FLAG_TIMING_SELECT,
  input wire logic I_OFFSET_LOAD_N,
  input wire logic I_DEFAULT_OFFSET_SEL0,
  input wire logic I_DEFAULT_OFFSET_SEL1,
  input wire logic I_WRITE_EN_N,
  input wire logic I_READ_EN_N,
  input wire logic I_READ_SELECT_N,
  input wire logic I_RETRANSMIT_MODE,
  input wire logic I_MARK,
  output logic O_WRITE_TAKEN,
  output logic O_READ_TAKEN,
  output logic [1:0] O_FULL_FLAG_N,
  output logic [1:0] O_EMPTY_FLAG_N,
  output logic [1:0] O_ALMOST_FULL_FLAG_N,
  output logic [1:0] O_ALMOST_EMPTY_FLAG_N
);
  import fsfl_pkg::*;

  localparam logic [PTR_W-1:0] DEPTH_W = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] ONE_W = PTR_W'(1);

  fsfl_regwr_type reg_wr;
  fsfl_cfg_type cfg_q;
  fsfl_flags_type flags [2];
  logic [`FSFL_ADDR_W-1:0] rd_addr;
  logic [`FSFL_DATA_W-1:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic rst_ptr;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W-1:0] mark_q;
  logic [PTR_W-1:0] ref_ptr;
  logic [PTR_W-1:0] mem_cnt;
  logic [PTR_W-1:0] full_cnt;
  logic [PTR_W-1:0] occ_cnt;
  logic [PTR_W-1:0] cap;
  logic [PTR_W-1:0] eofs_q [2];
  logic [PTR_W-1:0] fofs_q [2];
  logic full_now;
  logic full_s1_q;
  logic full_s2_q;
  logic empty_s1_q;
  logic empty_s2_q;
  logic ne_s1_q;
  logic ne_s2_q;
  logic out_valid_q;
  logic port_open;
  logic write_taken;
  logic std_read;
  logic true_read;
  logic load_out;
  logic [1:0] af_cond;
  logic [1:0] ae_cond;
  logic [1:0] af_c_q;
  logic [1:0] ae_c_q;
  logic [1:0] af_q;
  logic [1:0] ae_q;

  // Words between two pointers, plus the output register word when counted
  function automatic logic [PTR_W-1:0] occ(input logic [PTR_W-1:0] a,
                                           input logic [PTR_W-1:0] b, input logic extra);
    occ = a - b + PTR_W'(extra);
  endfunction : occ

  // Byte lane merge of a register write
  function automatic logic [`FSFL_DATA_W-1:0] merge(input logic [`FSFL_DATA_W-1:0] old,
                                                    input fsfl_regwr_type wr);
    merge = old;
    for (int i = 0; i < `FSFL_STRB_W; i++)
      if (wr.strb[i])
        merge[8*i +: 8] = wr.data[8*i +: 8];
  endfunction : merge

  // Default offset for the strap code taken at master reset
  function automatic logic [PTR_W-1:0] preset(input logic [2:0] sel);
    case (sel)
      3'h0: preset = PTR_W'(`FSFL_PRESET_0);
      3'h1: preset = PTR_W'(`FSFL_PRESET_1);
      3'h2: preset = PTR_W'(`FSFL_PRESET_2);
      3'h3: preset = PTR_W'(`FSFL_PRESET_3);
      3'h4: preset = PTR_W'(`FSFL_PRESET_4);
      3'h5: preset = PTR_W'(`FSFL_PRESET_5);
      3'h6: preset = PTR_W'(`FSFL_PRESET_6);
      default: preset = PTR_W'(`FSFL_PRESET_7);
    endcase
  endfunction : preset

  // Register address decode
  function automatic logic is_mapped(input logic [`FSFL_ADDR_W-1:0] a);
    case (a)
      `FSFL_ADDR_STATUS, `FSFL_ADDR_COUNT, `FSFL_ADDR_EOFS0,
      `FSFL_ADDR_EOFS1, `FSFL_ADDR_FOFS0, `FSFL_ADDR_FOFS1: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Bus slave
  fsfl_axil u_axil (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_axi_req(I_AXI_REQ),
    .o_axi_rsp(O_AXI_RSP),
    .o_reg_wr(reg_wr),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_hit(rd_hit),
    .i_wr_hit(wr_hit)
  );

  // Pointer reset from any of the three resets
  assign rst_ptr = I_SYS_RST || !I_MASTER_RESET_N || !I_PARTIAL_RESET_N;

  // Mode straps caught while master reset is held
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      cfg_q <= '0;
    else if (!I_MASTER_RESET_N)
      cfg_q <= '{fall_through_mode: I_FALL_THROUGH_MODE,
                 sync_timing: I_FLAG_TIMING_SELECT};
  end

  // Offset registers: preset at master reset, then written over the bus
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      eofs_q <= '{preset(3'h0), preset(3'h0)};
      fofs_q <= '{preset(3'h0), preset(3'h0)};
    end
    else if (!I_MASTER_RESET_N)
    begin
      eofs_q <= '{2{preset({I_OFFSET_LOAD_N, I_DEFAULT_OFFSET_SEL1,
                            I_DEFAULT_OFFSET_SEL0})}};
      fofs_q <= '{2{preset({I_OFFSET_LOAD_N, I_DEFAULT_OFFSET_SEL1,
                            I_DEFAULT_OFFSET_SEL0})}};
    end
    else if (reg_wr.en)
    begin
      case (reg_wr.addr)
        `FSFL_ADDR_EOFS0: eofs_q[0] <= PTR_W'(merge(32'(eofs_q[0]), reg_wr));
        `FSFL_ADDR_EOFS1: eofs_q[1] <= PTR_W'(merge(32'(eofs_q[1]), reg_wr));
        `FSFL_ADDR_FOFS0: fofs_q[0] <= PTR_W'(merge(32'(fofs_q[0]), reg_wr));
        `FSFL_ADDR_FOFS1: fofs_q[1] <= PTR_W'(merge(32'(fofs_q[1]), reg_wr));
        default: ;
      endcase
    end
  end

  // Occupancy seen by each side
  assign ref_ptr = I_RETRANSMIT_MODE ? mark_q : rd_ptr_q;
  assign mem_cnt = occ(wr_ptr_q, rd_ptr_q, 1'b0);
  assign full_cnt = occ(wr_ptr_q, ref_ptr, cfg_q.fall_through_mode && out_valid_q);
  assign occ_cnt = occ(wr_ptr_q, rd_ptr_q, cfg_q.fall_through_mode && out_valid_q);
  assign cap = cfg_q.fall_through_mode ? DEPTH_W + ONE_W : DEPTH_W;
  assign full_now = (full_cnt >= cap);

  // Port access, blocked while offsets are being loaded
  assign port_open = I_OFFSET_LOAD_N && !rst_ptr;
  assign write_taken = port_open && !I_WRITE_EN_N && !full_now && !full_s2_q;
  assign std_read = port_open && !cfg_q.fall_through_mode && !I_READ_EN_N
                    && !I_READ_SELECT_N && !empty_s2_q && (mem_cnt != '0);
  assign true_read = port_open && cfg_q.fall_through_mode && out_valid_q
                     && !I_READ_EN_N && !I_READ_SELECT_N;
  assign load_out = port_open && cfg_q.fall_through_mode && ne_s2_q
                    && (mem_cnt != '0) && (!out_valid_q || true_read);
  assign O_WRITE_TAKEN = write_taken;
  assign O_READ_TAKEN = std_read || true_read;

  // Write and read pointers, and the retransmit mark
  always_ff @(posedge I_CLOCK)
  begin
    if (rst_ptr)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      mark_q <= '0;
    end
    else
    begin
      if (write_taken)
        wr_ptr_q <= wr_ptr_q + ONE_W;
      if (std_read || load_out)
        rd_ptr_q <= rd_ptr_q + ONE_W;
      if (I_MARK)
        mark_q <= rd_ptr_q;
    end
  end

  // Full / input-ready pipeline, two stages
  always_ff @(posedge I_CLOCK)
  begin
    if (rst_ptr)
    begin
      full_s1_q <= 1'b0;
      full_s2_q <= 1'b0;
    end
    else
    begin
      full_s1_q <= full_now;
      full_s2_q <= full_s1_q;
    end
  end

  // Empty pipeline, two stages; output-ready path, three stages
  always_ff @(posedge I_CLOCK)
  begin
    if (rst_ptr)
    begin
      empty_s1_q <= 1'b1;
      empty_s2_q <= 1'b1;
      ne_s1_q <= 1'b0;
      ne_s2_q <= 1'b0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      empty_s1_q <= (mem_cnt == '0);
      empty_s2_q <= empty_s1_q;
      ne_s1_q <= (mem_cnt != '0);
      ne_s2_q <= ne_s1_q;
      if (load_out)
        out_valid_q <= 1'b1;
      else if (true_read)
        out_valid_q <= 1'b0;
    end
  end

  // Almost conditions per die, each die with its own offsets
  always_comb
  begin
    for (int d = 0; d < 2; d++)
    begin
      af_cond[d] = ({1'b0, full_cnt} + {1'b0, fofs_q[d]} >= {1'b0, cap});
      ae_cond[d] = cfg_q.fall_through_mode ? ({1'b0, occ_cnt} <= {1'b0, eofs_q[d]} + ONE_W)
                                           : (occ_cnt <= eofs_q[d]);
    end
  end

  // Almost flags: one stage when asynchronous, two when synchronous
  always_ff @(posedge I_CLOCK)
  begin
    if (rst_ptr)
    begin
      af_c_q <= '0;
      ae_c_q <= '1;
      af_q <= '0;
      ae_q <= '1;
    end
    else
    begin
      af_c_q <= af_cond;
      ae_c_q <= ae_cond;
      af_q <= cfg_q.sync_timing ? af_c_q : af_cond;
      ae_q <= cfg_q.sync_timing ? ae_c_q : ae_cond;
    end
  end

  // Pin levels of both dies
  always_comb
  begin
    for (int d = 0; d < 2; d++)
    begin
      flags[d].full_flag_n = cfg_q.fall_through_mode ? full_s2_q : !full_s2_q;
      flags[d].empty_flag_n = cfg_q.fall_through_mode ? !out_valid_q : !empty_s2_q;
      flags[d].almost_full_flag_n = !af_q[d];
      flags[d].almost_empty_flag_n = !ae_q[d];
      O_FULL_FLAG_N[d] = flags[d].full_flag_n;
      O_EMPTY_FLAG_N[d] = flags[d].empty_flag_n;
      O_ALMOST_FULL_FLAG_N[d] = flags[d].almost_full_flag_n;
      O_ALMOST_EMPTY_FLAG_N[d] = flags[d].almost_empty_flag_n;
    end
  end

  // Register read decode
  assign rd_hit = is_mapped(rd_addr);
  assign wr_hit = is_mapped(reg_wr.addr);
  always_comb
  begin
    case (rd_addr)
      `FSFL_ADDR_STATUS: rd_data = 32'({flags[1], flags[0], cfg_q});
      `FSFL_ADDR_COUNT: rd_data = 32'(occ_cnt);
      `FSFL_ADDR_EOFS0: rd_data = 32'(eofs_q[0]);
      `FSFL_ADDR_EOFS1: rd_data = 32'(eofs_q[1]);
      `FSFL_ADDR_FOFS0: rd_data = 32'(fofs_q[0]);
      `FSFL_ADDR_FOFS1: rd_data = 32'(fofs_q[1]);
      default: rd_data = '0;
    endcase
  end

  // Checks
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (rst_ptr);

  sequence s_word_waiting;
    cfg_q.fall_through_mode && !out_valid_q && (mem_cnt != '0) && I_OFFSET_LOAD_N;
  endsequence

  sequence s_fall_through;
    s_word_waiting [*3];
  endsequence

  AST_FULL_BLOCKS: assert property (full_s2_q |=> $stable(wr_ptr_q))
    else $error("write taken while full flag active");
  AST_NO_OVERFILL: assert property (full_cnt <= cap)
    else $error("occupancy above capacity");
  AST_IR_BLOCKS: assert property (cfg_q.fall_through_mode && O_FULL_FLAG_N[0]
                                  |-> !O_WRITE_TAKEN)
    else $error("write taken while input-ready high");
  AST_FULL_PIPE: assert property (full_now |-> ##2 full_s2_q)
    else $error("full flag not two cycles after full");
  AST_EMPTY_PIPE: assert property ((mem_cnt == '0) ##1 (mem_cnt == '0)
                                   |-> ##1 empty_s2_q)
    else $error("empty flag missing two cycles after empty");
  AST_EMPTY_IGNORE: assert property (!cfg_q.fall_through_mode && (mem_cnt == '0)
                                     |-> !O_READ_TAKEN ##1 (rd_ptr_q == $past(rd_ptr_q)))
    else $error("read taken while empty");
  AST_OR_FIRST: assert property (s_fall_through |=> out_valid_q)
    else $error("first word did not fall through in three cycles");
  AST_OR_HOLD: assert property (out_valid_q && !true_read |=> out_valid_q)
    else $error("output-ready rose without a true read");
  AST_OR_LAST: assert property (true_read && (mem_cnt == '0) |=> !out_valid_q)
    else $error("output-ready stayed low after last read");
  AST_AF_ASYNC: assert property (!cfg_q.sync_timing && af_cond[0]
                                 |=> !O_ALMOST_FULL_FLAG_N[0])
    else $error("asynchronous almost-full late");
  AST_AE_SYNC: assert property (cfg_q.sync_timing && $stable(cfg_q) && ae_cond[1]
                                |-> ##2 !O_ALMOST_EMPTY_FLAG_N[1])
    else $error("synchronous almost-empty not two cycles after condition");
  AST_RESET_EMPTY: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
                                    !I_PARTIAL_RESET_N |=> (mem_cnt == '0) && !out_valid_q
                                    && !O_ALMOST_EMPTY_FLAG_N[0])
    else $error("partial reset left data or flags");
  AST_STRAP_TIMING: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
                                     !I_MASTER_RESET_N
                                     |=> cfg_q.sync_timing == $past(I_FLAG_TIMING_SELECT))
    else $error("timing strap not captured");

endmodule : fsfl_flags

// file: fsfl_consts.svh
// Constants for the FIFO status flag block: depth, register map, bus answers, presets.
// Assumes inclusion by the package and by every design file that needs a number.
`ifndef FSFL_CONSTS_SVH
`define FSFL_CONSTS_SVH

// Memory depth in words
`define FSFL_DEPTH 524288

// Register bus widths
`define FSFL_ADDR_W 8
`define FSFL_DATA_W 32
`define FSFL_STRB_W 4

// Register byte addresses
`define FSFL_ADDR_STATUS 8'h00
`define FSFL_ADDR_COUNT 8'h04
`define FSFL_ADDR_EOFS0 8'h08
`define FSFL_ADDR_EOFS1 8'h0c
`define FSFL_ADDR_FOFS0 8'h10
`define FSFL_ADDR_FOFS1 8'h14

// Bus response codes
`define FSFL_RESP_OKAY 2'h0
`define FSFL_RESP_SLVERR 2'h2

// Default offset presets, selected at master reset (values arbitrary)
`define FSFL_PRESET_0 32'h00000007
`define FSFL_PRESET_1 32'h0000001f
`define FSFL_PRESET_2 32'h0000003f
`define FSFL_PRESET_3 32'h0000007f
`define FSFL_PRESET_4 32'h000000ff
`define FSFL_PRESET_5 32'h000001ff
`define FSFL_PRESET_6 32'h000003ff
`define FSFL_PRESET_7 32'h00000003

`endif

// file: fsfl_pkg.sv
// Types shared by the FIFO status flag block and its register bus slave.
// Assumes fsfl_consts.svh is on the include path.
`include "fsfl_consts.svh"

package fsfl_pkg;

  // Bus requests from the master
  typedef struct packed {
    logic awvalid;
    logic [`FSFL_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`FSFL_DATA_W-1:0] wdata;
    logic [`FSFL_STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`FSFL_ADDR_W-1:0] araddr;
    logic rready;
  } fsfl_axi_req_type;

  // Bus answers from the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`FSFL_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } fsfl_axi_rsp_type;

  // One register write, passed from the slave to the register file
  typedef struct packed {
    logic en;
    logic [`FSFL_ADDR_W-1:0] addr;
    logic [`FSFL_DATA_W-1:0] data;
    logic [`FSFL_STRB_W-1:0] strb;
  } fsfl_regwr_type;

  // Configuration caught at master reset
  typedef struct packed {
    logic fall_through_mode;
    logic sync_timing;
  } fsfl_cfg_type;

  // Flag levels of one die, all active low
  typedef struct packed {
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_full_flag_n;
    logic almost_empty_flag_n;
  } fsfl_flags_type;

  // Write channel state of the bus slave
  typedef enum logic [0:0] {
    WST_COLLECT = 1'b0,
    WST_RESP = 1'b1
  } fsfl_wst_type;

endpackage : fsfl_pkg

// file: fsfl_axil.sv
// AXI4-Lite slave for the FIFO status flag block.
// Assumes a master that holds valid and payload until ready; one write, one read at a time.
`timescale 1ns/1ps
`include "fsfl_consts.svh"

module fsfl_axil (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire fsfl_pkg::fsfl_axi_req_type i_axi_req,
  output fsfl_pkg::fsfl_axi_rsp_type o_axi_rsp,
  output fsfl_pkg::fsfl_regwr_type o_reg_wr,
  output logic [`FSFL_ADDR_W-1:0] o_rd_addr,
  input wire logic [`FSFL_DATA_W-1:0] i_rd_data,
  input wire logic i_rd_hit,
  input wire logic i_wr_hit
);
  import fsfl_pkg::*;

  fsfl_wst_type wst_q;
  logic aw_q;
  logic w_q;
  logic [`FSFL_ADDR_W-1:0] awaddr_q;
  logic [`FSFL_DATA_W-1:0] wdata_q;
  logic [`FSFL_STRB_W-1:0] wstrb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [`FSFL_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;

  // Channel handshakes
  assign aw_take = i_axi_req.awvalid && !aw_q && (wst_q == WST_COLLECT);
  assign w_take = i_axi_req.wvalid && !w_q && (wst_q == WST_COLLECT);
  assign wr_fire = aw_q && w_q && (wst_q == WST_COLLECT);
  assign ar_take = i_axi_req.arvalid && !rvalid_q;

  // Address and data captured in either order
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_q <= 1'b1;
        awaddr_q <= i_axi_req.awaddr;
      end
      else if (wr_fire)
        aw_q <= 1'b0;
      if (w_take)
      begin
        w_q <= 1'b1;
        wdata_q <= i_axi_req.wdata;
        wstrb_q <= i_axi_req.wstrb;
      end
      else if (wr_fire)
        w_q <= 1'b0;
    end
  end

  // Write response sequencing
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      wst_q <= WST_COLLECT;
      bresp_q <= `FSFL_RESP_OKAY;
    end
    else
    begin
      case (wst_q)
        WST_COLLECT:
        begin
          if (wr_fire)
          begin
            wst_q <= WST_RESP;
            bresp_q <= i_wr_hit ? `FSFL_RESP_OKAY : `FSFL_RESP_SLVERR;
          end
        end
        WST_RESP:
        begin
          if (i_axi_req.bready)
            wst_q <= WST_COLLECT;
        end
        default: wst_q <= WST_COLLECT;
      endcase
    end
  end

  // Read channel: data registered at the address handshake
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `FSFL_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= i_rd_hit ? i_rd_data : '0;
      rresp_q <= i_rd_hit ? `FSFL_RESP_OKAY : `FSFL_RESP_SLVERR;
    end
    else if (rvalid_q && i_axi_req.rready)
      rvalid_q <= 1'b0;
  end

  // Outputs
  assign o_rd_addr = i_axi_req.araddr;
  assign o_reg_wr = '{en: wr_fire, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
  assign o_axi_rsp = '{awready: !aw_q && (wst_q == WST_COLLECT),
                       wready: !w_q && (wst_q == WST_COLLECT),
                       bvalid: (wst_q == WST_RESP), bresp: bresp_q,
                       arready: !rvalid_q, rvalid: rvalid_q,
                       rdata: rdata_q, rresp: rresp_q};

endmodule : fsfl_axil

// file: fsfl_ctrl_model.sv
// Far-side controller model: combines the two dies' flags as outside logic must.
// Assumes flag levels from the block and the mode strap that the block latched.
`timescale 1ns/1ps

module fsfl_ctrl_model (
  input wire logic i_fall_through_mode,
  input wire logic [1:0] i_full_flag_n,
  input wire logic [1:0] i_empty_flag_n,
  input wire logic [1:0] i_almost_full_flag_n,
  output logic o_full_gated_n,
  output logic o_empty_gated_n,
  output logic [1:0] o_watermark_n
);
  // OR gate in fall-through, AND gate in standard, hiding skew between dies
  assign o_full_gated_n = i_fall_through_mode ? |i_full_flag_n : &i_full_flag_n;
  assign o_empty_gated_n = i_fall_through_mode ? |i_empty_flag_n : &i_empty_flag_n;
  // Each die's almost-full flag is kept as its own watermark
  assign o_watermark_n = i_almost_full_flag_n;
endmodule : fsfl_ctrl_model

// file: tb_top.sv
// Testbench for the FIFO status flag block with an occupancy model and bus tasks.
// Assumes a small depth, settled flags before each request and a synchronous reset.
`timescale 1ns/1ps
`include "fsfl_consts.svh"

module tb_top;
  import fsfl_pkg::*;
  localparam int D = 16;
  logic clk = '0, rst = '1, mrs_n = '1, prs_n = '1, ft = '0, tsel = '0;
  logic ld_n = '1, s0 = '0, s1 = '0, wen_n = '1, ren_n = '1, wt, rt, fg, eg;
  logic rtm = '0, mk = '0, rsel_n = '0;
  int rtw = 0;
  logic [1:0] ff, ef, af, ae, wm, resp;
  logic [31:0] rs = 32'h36, rd;
  logic [31:0] pre[8] = '{`FSFL_PRESET_0, `FSFL_PRESET_1, `FSFL_PRESET_2, `FSFL_PRESET_3,
    `FSFL_PRESET_4, `FSFL_PRESET_5, `FSFL_PRESET_6, `FSFL_PRESET_7};
  fsfl_axi_req_type req = '0;
  fsfl_axi_rsp_type rsp;
  int cnt = 0, cap = D, bad_count = 0, checks = 0, cyc = 0;
  int thr_n[2], thr_m[2];

  fsfl_flags #(.DEPTH(D)) fsfl_flags_inst (.I_CLOCK(clk), .I_SYS_RST(rst), .I_AXI_REQ(req),
    .O_AXI_RSP(rsp), .I_MASTER_RESET_N(mrs_n), .I_PARTIAL_RESET_N(prs_n),
    .I_FALL_THROUGH_MODE(ft), .I_FLAG_TIMING_SELECT(tsel), .I_OFFSET_LOAD_N(ld_n),
    .I_DEFAULT_OFFSET_SEL0(s0), .I_DEFAULT_OFFSET_SEL1(s1), .I_WRITE_EN_N(wen_n),
    .I_READ_EN_N(ren_n), .I_READ_SELECT_N(rsel_n), .I_RETRANSMIT_MODE(rtm), .I_MARK(mk),
    .O_WRITE_TAKEN(wt), .O_READ_TAKEN(rt), .O_FULL_FLAG_N(ff), .O_EMPTY_FLAG_N(ef),
    .O_ALMOST_FULL_FLAG_N(af), .O_ALMOST_EMPTY_FLAG_N(ae));

  fsfl_ctrl_model fsfl_ctrl_model_inst (.i_fall_through_mode(ft), .i_full_flag_n(ff),
    .i_empty_flag_n(ef), .i_almost_full_flag_n(af), .o_full_gated_n(fg),
    .o_empty_gated_n(eg), .o_watermark_n(wm));

  // Clock of 100 ns
  initial forever #50 clk = ~clk;

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Expected {full, empty, almost-full, almost-empty} of one die
  function automatic logic [3:0] exp_f(input int d);
    int fc;
    fc = rtm ? rtw : cnt; // Retransmit measures fullness from the mark
    return {ft ? fc >= cap : fc < cap, ft ? cnt == 0 : cnt > 0,
      fc < cap - thr_m[d], cnt > thr_n[d] + ft};
  endfunction : exp_f

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awvalid <= '1;
    req.awaddr <= a;
    req.wvalid <= '1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= '1;
    do
    begin
      @(posedge clk);
      if (rsp.awready && req.awvalid) req.awvalid <= '0;
      if (rsp.wready && req.wvalid) req.wvalid <= '0;
    end while (!(rsp.bvalid && req.bready));
    req.bready <= '0;
    resp = rsp.bresp;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge clk);
    req.arvalid <= '1;
    req.araddr <= a;
    req.rready <= '1;
    do
    begin
      @(posedge clk);
      if (rsp.arready && req.arvalid) req.arvalid <= '0;
    end while (!(rsp.rvalid && req.rready));
    req.rready <= '0;
    rd = rsp.rdata;
    resp = rsp.rresp;
  endtask : axi_rd

  task chk_flags;
    logic [3:0] e0, e1;
    e0 = exp_f(0);
    e1 = exp_f(1);
    chk({ff[0], ef[0], af[0], ae[0]}, e0);
    chk({ff[1], ef[1], af[1], ae[1]}, e1);
    chk({fg, eg, wm}, {e0[3:2], e1[1], e0[1]});
  endtask : chk_flags

  // One write or read, then the flags once they have settled
  task do_op(input logic w);
    logic ok;
    logic ds;
    ds = !w && rs[3:2] == 2'h3;
    ok = w ? (rtm ? rtw : cnt) < cap : cnt > 0 && !ds;
    @(posedge clk);
    if (w) wen_n <= '0;
    else ren_n <= '0;
    rsel_n <= ds;
    @(negedge clk);
    chk({wt, rt}, {w & ok, !w & ok});
    if (ok) cnt += w ? 1 : -1;
    if (ok && w) rtw++;
    @(posedge clk);
    wen_n <= '1;
    ren_n <= '1;
    rsel_n <= '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk_flags();
  endtask : do_op

  // Every preset code, mode and timing, each with a fill, partial reset and drain
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= '0;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk);
      mrs_n <= '0;
      ft <= c[0];
      tsel <= c[1];
      {ld_n, s1, s0} <= c[2:0];
      repeat (2) @(posedge clk);
      mrs_n <= '1;
      ld_n <= '1;
      cnt = 0;
      cap = D + c[0];
      thr_n = '{2{pre[c] & (2 * D - 1)}};
      thr_m = '{2{pre[c] & (2 * D - 1)}};
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_flags();
      axi_rd(`FSFL_ADDR_STATUS);
      chk(rd[9:0], {exp_f(1), exp_f(0), ft, tsel});
      axi_wr(`FSFL_ADDR_EOFS1, 32'h1);
      axi_wr(`FSFL_ADDR_FOFS1, 32'h2);
      chk(resp, `FSFL_RESP_OKAY);
      thr_n[1] = 1;
      thr_m[1] = 2;
      axi_rd(8'h18);
      chk(resp, `FSFL_RESP_SLVERR);
      chk(rd, 32'h0);
      for (int i = 0; i < 80; i++)
      begin
        rs = xs(rs);
        do_op((i < 40) == (rs[1:0] != 2'h0));
        if (i == 39)
        begin
          axi_rd(`FSFL_ADDR_COUNT);
          chk(rd, cnt);
          @(posedge clk);
          prs_n <= '0;
          @(posedge clk);
          prs_n <= '1;
          cnt = 0;
          repeat (3) @(posedge clk);
          @(negedge clk);
          chk_flags();
        end
      end
      if (c == 0)
      begin
        // Retransmit: fill, drain, overfill from the mark, then move the mark
        @(posedge clk);
        prs_n <= '0;
        rtm <= '1;
        @(posedge clk);
        prs_n <= '1;
        cnt = 0;
        rtw = 0;
        repeat (12) do_op(1'b1);
        repeat (12) do_op(1'b0);
        repeat (5) do_op(1'b1);
        @(posedge clk);
        mk <= '1;
        @(posedge clk);
        mk <= '0;
        rtw = cnt;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk_flags();
        rtm <= '0;
      end
    end
    finish_test();
  end
endmodule : tb_top
